//--- logic/uaix_pkg.sv
package uaix_pkg;
	localparam logic [7:0] SPC_ENABLE_ADDR = 8'h05;
	localparam logic [7:0] SPC_FLAGS_ADDR  = 8'h06;
	localparam logic [7:0] STS_ENABLE_ADDR = 8'h07;
	localparam logic [7:0] STS_FLAGS_ADDR  = 8'h08;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [5:0] SPC_RESET       = 6'h00;
	localparam logic [3:0] PIN_RESET       = 4'h0;
	localparam int         SPC_WIDTH       = 6;
	localparam int         PIN_WIDTH       = 4;
	localparam int         ADDR_CHAR_BIT   = 5;
	localparam int         HOLD_LOW_BIT    = 4;
	localparam int         PAUSE_B_BIT     = 3;
	localparam int         PAUSE_A_BIT     = 2;
	localparam int         RESUME_B_BIT    = 1;
	localparam int         RESUME_A_BIT    = 0;
	localparam int         CLK_SETTLED_BIT = 5;
	localparam int         CHANNEL_COUNT   = 4;
	localparam int         PIN_TOTAL       = 16;
	localparam logic [1:0] CHANNEL_INDEX   = 2'h0;
endpackage

//--- logic/uaix_sources.sv
// Behaviour
// - Special enable register gates six event flags
// - Special flag reaches summary only when gated
// - Reading special flags register clears all
// - Address character in multidrop sets flag
// - Long low line sets hold-low flag
// - Pause/resume flags need detection mode enabled
// - Status enable bit 5 gates settled flag
// - Status enable bits 3..0 gate pin flags
// - Channel n uses pins 4n to 4n+3
// - Pin toggle either way sets change flag
// - Gated-off pin never sets its flag
// - Reading status flags clears pin flags
// - Settled flag set when clock stable
// - Settled flag valid only for internal sources
// - Settled flag clears when clock not stable or external
// - Unused bits read zero after reset
// - Top status read clears special summary
// - Enabled status flag sets status summary
`timescale 1ns/1ps
module uaix_sources
	import uaix_pkg::*;
#(
	parameter logic [1:0] CHANNEL = uaix_pkg::CHANNEL_INDEX
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	input  wire logic                         clk_en,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	output logic      [7:0]                   reg_rdata,
	input  wire logic                         top_status_rd,
	input  wire logic                         rx_char_done,
	input  wire logic                         rx_address_char,
	input  wire logic                         rx_line_hold_low,
	input  wire logic [3:0]                   rx_special_match,
	input  wire logic                         multidrop_mode,
	input  wire logic                         special_detect_mode,
	input  wire logic                         clock_stable,
	input  wire logic                         external_clock_input,
	input  wire logic [uaix_pkg::PIN_TOTAL-1:0] gpio_pins,
	output logic                              special_char_summary,
	output logic                              status_summary
);
	import uaix_pkg::*;

	typedef struct packed {
		logic [SPC_WIDTH-1:0] spc_en;
		logic [SPC_WIDTH-1:0] spc_flag;
		logic                 settled_en;
		logic [PIN_WIDTH-1:0] pin_en;
		logic                 settled;
		logic [PIN_WIDTH-1:0] pin_flag;
		logic [PIN_WIDTH-1:0] pin_s1;
		logic [PIN_WIDTH-1:0] pin_s2;
		logic [PIN_WIDTH-1:0] pin_s3;
		logic [1:0]           stable_s;
		logic                 spc_sum;
		logic                 sts_sum;
		logic [7:0]           rdata;
	} uaix_state_type;

	uaix_state_type st_q;
	uaix_state_type st_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic [PIN_WIDTH-1:0] my_pins;
	logic [SPC_WIDTH-1:0] spc_set;
	logic [PIN_WIDTH-1:0] pin_set;
	logic                 rd_spc;
	logic                 rd_sts;
	logic                 settled_now;

	// Channel slice of the shared pin bus
	genvar gi;
	generate
		for (gi = 0; gi < PIN_WIDTH; gi++) begin : g_pin
			assign my_pins[gi] = gpio_pins[PIN_WIDTH * CHANNEL + gi];
		end
	endgenerate

	always_comb begin
		rd_spc = reg_rd && hit(reg_addr, SPC_FLAGS_ADDR);
		rd_sts = reg_rd && hit(reg_addr, STS_FLAGS_ADDR);
		spc_set = '0;
		if (rx_char_done && rx_address_char && multidrop_mode) begin
			spc_set[ADDR_CHAR_BIT] = 1'h1;
		end
		spc_set[HOLD_LOW_BIT] = rx_line_hold_low;
		if (rx_char_done && special_detect_mode) begin
			spc_set[PAUSE_B_BIT:RESUME_A_BIT] = rx_special_match;
		end
		// Toggle seen on synchronised copies only
		pin_set = (st_q.pin_s2 ^ st_q.pin_s3) & st_q.pin_en;
		// External clock gives no settle indication, hold flag low
		settled_now = st_q.stable_s[1] && !external_clock_input;
	end

	always_comb begin
		st_d = st_q;
		st_d.pin_s1 = my_pins;
		st_d.pin_s2 = st_q.pin_s1;
		st_d.pin_s3 = st_q.pin_s2;
		st_d.stable_s = {st_q.stable_s[0], clock_stable};
		if (reg_wr && hit(reg_addr, SPC_ENABLE_ADDR)) begin
			st_d.spc_en = reg_wdata[SPC_WIDTH-1:0];
		end
		if (reg_wr && hit(reg_addr, STS_ENABLE_ADDR)) begin
			st_d.settled_en = reg_wdata[CLK_SETTLED_BIT];
			st_d.pin_en = reg_wdata[PIN_WIDTH-1:0];
		end
		// Set wins over the clearing read
		st_d.spc_flag = (rd_spc ? SPC_RESET : st_q.spc_flag)
			| spc_set;
		st_d.pin_flag = (rd_sts ? PIN_RESET : st_q.pin_flag)
			| pin_set;
		st_d.settled = settled_now;
		st_d.rdata = REG_RESET;
		if (reg_rd) begin
			unique case (reg_addr)
				SPC_ENABLE_ADDR: st_d.rdata = {2'h0, st_q.spc_en};
				SPC_FLAGS_ADDR:  st_d.rdata = {2'h0, st_q.spc_flag};
				STS_ENABLE_ADDR: st_d.rdata = {2'h0, st_q.settled_en, 1'h0,
					st_q.pin_en};
				STS_FLAGS_ADDR:  st_d.rdata = {2'h0, st_q.settled, 1'h0,
					st_q.pin_flag};
				default:         st_d.rdata = REG_RESET;
			endcase
		end
		st_d.spc_sum = (top_status_rd ? 1'h0 : st_q.spc_sum)
			| |(st_q.spc_flag & st_q.spc_en);
		st_d.sts_sum = (top_status_rd ? 1'h0 : st_q.sts_sum)
			| |(st_q.pin_flag & st_q.pin_en)
			| (st_q.settled & st_q.settled_en);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign special_char_summary = st_q.spc_sum;
	assign status_summary = st_q.sts_sum;

	// Every check is gated by clk_en: a frozen cycle promises nothing
	a_spc_read_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_spc && spc_set == '0
		|=> st_q.spc_flag == '0)
		else $error("special flags not cleared by read");

	a_pin_read_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_sts && pin_set == '0
		|=> st_q.pin_flag == '0)
		else $error("pin flags not cleared by read");

	a_settled_keep: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_sts && settled_now
		|=> st_q.settled)
		else $error("settled flag lost on read");

	a_spc_gate: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !top_status_rd && |(st_q.spc_flag & st_q.spc_en)
		|=> special_char_summary)
		else $error("special summary missed");

	a_spc_masked: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && top_status_rd && st_q.spc_en == '0
		|=> !special_char_summary)
		else $error("special summary not cleared");

	a_sts_gate: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && st_q.settled && st_q.settled_en
		|=> status_summary)
		else $error("status summary missed");

	a_pin_masked: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_sts && st_q.pin_en == '0
		|=> st_q.pin_flag == '0)
		else $error("masked pin set its flag");

	a_set_wins: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_spc && rx_line_hold_low
		|=> st_q.spc_flag[HOLD_LOW_BIT])
		else $error("event lost on clearing read");

	a_pause_mode: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_spc && !special_detect_mode && !rx_line_hold_low
		&& !(rx_char_done && rx_address_char && multidrop_mode)
		|=> st_q.spc_flag == '0)
		else $error("pause flag set with detection off");

	a_spc_clear_top: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && top_status_rd && (st_q.spc_flag & st_q.spc_en) == '0
		|=> !special_char_summary)
		else $error("special summary survived top read");

	// A gated flag still high re-arms the summary right after the read
	a_sts_clear_top: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && top_status_rd && (st_q.pin_flag & st_q.pin_en) == '0
		&& !(st_q.settled && st_q.settled_en)
		|=> !status_summary)
		else $error("status summary survived top read");

	a_addr_char_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_char_done && rx_address_char && multidrop_mode
		|=> st_q.spc_flag[ADDR_CHAR_BIT])
		else $error("address character flag missed");

	a_addr_mode_off: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_spc && !multidrop_mode
		|=> !st_q.spc_flag[ADDR_CHAR_BIT])
		else $error("address flag set outside multidrop");

	a_hold_low_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_line_hold_low
		|=> st_q.spc_flag[HOLD_LOW_BIT])
		else $error("hold-low flag missed");

	a_pause_b_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_char_done && special_detect_mode
		&& rx_special_match[PAUSE_B_BIT] |=> st_q.spc_flag[PAUSE_B_BIT])
		else $error("second pause flag missed");

	a_pause_a_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_char_done && special_detect_mode
		&& rx_special_match[PAUSE_A_BIT] |=> st_q.spc_flag[PAUSE_A_BIT])
		else $error("first pause flag missed");

	a_resume_b_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_char_done && special_detect_mode
		&& rx_special_match[RESUME_B_BIT] |=> st_q.spc_flag[RESUME_B_BIT])
		else $error("second resume flag missed");

	a_resume_a_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rx_char_done && special_detect_mode
		&& rx_special_match[RESUME_A_BIT] |=> st_q.spc_flag[RESUME_A_BIT])
		else $error("first resume flag missed");

	a_pin_any_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && pin_set != '0
		|=> st_q.pin_flag != '0)
		else $error("pin change lost");

	a_pin_quiet_read: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_sts && (st_q.pin_s2 ^ st_q.pin_s3) == '0
		|=> st_q.pin_flag == '0)
		else $error("pin flag set without a change");

	a_settled_ext: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && external_clock_input
		|=> !st_q.settled)
		else $error("settled flag shown on external clock");

	a_settled_rise: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && st_q.stable_s[1] && !external_clock_input
		|=> st_q.settled)
		else $error("settled flag not raised");

	a_settled_drop: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !st_q.stable_s[1]
		|=> !st_q.settled)
		else $error("settled flag kept after clock loss");

	a_spare_top_zero: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd
		|=> reg_rdata[7:6] == '0)
		else $error("spare top bits read nonzero");

	a_spare_mid_zero: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && (hit(reg_addr, STS_ENABLE_ADDR)
		|| hit(reg_addr, STS_FLAGS_ADDR)) |=> !reg_rdata[4])
		else $error("spare status bit read nonzero");

	// Read data stands one cycle, then drops back to zero
	a_rdata_idle: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !reg_rd
		|=> reg_rdata == '0)
		else $error("read data not idle");

	a_spc_en_write: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_wr && hit(reg_addr, SPC_ENABLE_ADDR)
		&& reg_wdata[ADDR_CHAR_BIT] |=> st_q.spc_en[ADDR_CHAR_BIT])
		else $error("special gate write lost");

	a_sts_en_write: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_wr && hit(reg_addr, STS_ENABLE_ADDR)
		&& reg_wdata[CLK_SETTLED_BIT] |=> st_q.settled_en)
		else $error("settled gate write lost");

	a_sts_pin_gate: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && (st_q.pin_flag & st_q.pin_en) != '0
		|=> status_summary)
		else $error("gated pin flag missed summary");

	a_spc_sum_idle: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !st_q.spc_sum && (st_q.spc_flag & st_q.spc_en) == '0
		|=> !special_char_summary)
		else $error("special summary without gated flag");

	// Per-pin check, independent of the pin_set expression
	genvar gc;
	generate
		for (gc = 0; gc < PIN_WIDTH; gc++) begin : g_pin_chk
			a_pin_toggle: assert property (
				@(posedge ref_clk) disable iff (!rst_n)
				clk_en && st_q.pin_en[gc]
				&& st_q.pin_s2[gc] != st_q.pin_s3[gc]
				|=> st_q.pin_flag[gc])
				else $error("pin toggle flag missed");
		end
	endgenerate
endmodule

//--- dv/uaix_far_end.sv
`timescale 1ns/1ps
module uaix_far_end (
	input  wire logic        ref_clk,
	input  wire logic        fire,
	input  wire logic [2:0]  kind,
	input  wire logic [15:0] flip,
	output logic             rx_char_done,
	output logic             rx_address_char,
	output logic             rx_line_hold_low,
	output logic [3:0]       rx_special_match,
	output logic [15:0]      gpio_pins
);
	// Kinds 0..3 match characters, 4 is a break, 5 an address character
	initial begin
		{rx_char_done, rx_address_char, rx_line_hold_low} = 3'h0;
		{rx_special_match, gpio_pins} = 20'h0_0000;
	end
	always @(posedge ref_clk) begin
		rx_char_done <= fire && kind != 3'h4;
		rx_address_char <= fire && kind == 3'h5;
		rx_line_hold_low <= fire && kind == 3'h4;
		rx_special_match <= (fire && kind < 3'h4) ?
			4'(4'h1 << kind) : 4'h0;
		gpio_pins <= gpio_pins ^ flip;
	end
endmodule

//--- dv/uaix_tb.sv
`timescale 1ns/1ps
module uart_aux_interrupt_sources_tb;
	import uaix_pkg::*;
	logic		ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic		top_rd = 1'b0, md = 1'b0, sd = 1'b0, cs = 1'b0, xc = 1'b0;
	logic		ce = 1'b1;
	logic		fire = 1'b0, pend = 1'b0, cd, ac, hl, s_sum, t_sum;
	logic [2:0]	kind = 3'h0;
	logic [3:0]	sm, p;
	logic [7:0]	addr = 8'h00, wd = 8'h00, rdata, d;
	logic [15:0]	flip = 16'h0000, pins;
	logic [9:0]	notes[$];
	int		n_errors = 0, tests_run = 0;
	uaix_sources #(.CHANNEL(2'h1)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
		.top_status_rd(top_rd), .rx_char_done(cd), .rx_address_char(ac),
		.rx_line_hold_low(hl), .rx_special_match(sm), .multidrop_mode(md),
		.special_detect_mode(sd), .clock_stable(cs),
		.external_clock_input(xc), .gpio_pins(pins),
		.special_char_summary(s_sum), .status_summary(t_sum));
	uaix_far_end far_u (.ref_clk(ref_clk), .fire(fire), .kind(kind),
		.flip(flip), .rx_char_done(cd), .rx_address_char(ac),
		.rx_line_hold_low(hl), .rx_special_match(sm), .gpio_pins(pins));
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) pend <= reg_rd;
	// Compared at the falling edge, where the read answer has settled
	always @(negedge ref_clk) if (pend)
		check({s_sum, t_sum, rdata}, notes.pop_front());
	task automatic check(logic [9:0] seen, logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH sums_rdata exp %h seen %h", exp, seen);
		end
	endtask
	task automatic acc(logic w, logic [7:0] a, logic [9:0] v);
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= {w, !w};
		addr <= a;
		wd <= v[7:0];
		if (!w) notes.push_back(v);
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= 2'h0;
	endtask
	task automatic ev(logic [2:0] k, logic [15:0] f);
		@(posedge ref_clk);
		fire <= (k != 3'h7);
		kind <= k;
		flip <= f;
		@(posedge ref_clk);
		{fire, flip} <= 17'h0_0000;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic tsr();
		@(posedge ref_clk);
		top_rd <= 1'b1;
		@(posedge ref_clk);
		top_rd <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#50us;
		n_errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'he3d8));
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 5; a < 10; a++) acc(1'b0, 8'(a), 10'h000);
		d = 8'($urandom);
		for (int a = 5; a < 10; a++) acc(1'b1, 8'(a), {2'h0, d});
		acc(1'b0, 8'h05, {2'h0, d & 8'h3f});
		acc(1'b0, 8'h07, {2'h0, d & 8'h2f});
		ev(3'h0, 16'h0000);
		ev(3'h5, 16'h0000);
		acc(1'b0, 8'h06, 10'h000);
		md <= 1'b1;
		sd <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			acc(1'b1, 8'h05, 10'h000);
			ev(3'(k), 16'h0000);
			acc(1'b0, 8'h06, 10'(8'h01 << k));
			acc(1'b1, 8'h05, 10'(8'h01 << k));
			ev(3'(k), 16'h0000);
			acc(1'b0, 8'h06, 10'h200 | 10'(8'h01 << k));
			acc(1'b0, 8'h06, 10'h200);
			tsr();
			acc(1'b0, 8'h06, 10'h000);
		end
		acc(1'b1, 8'h07, 10'h000);
		ev(3'h7, 16'h00f0);
		acc(1'b0, 8'h08, 10'h000);
		acc(1'b1, 8'h07, 10'h00f);
		p = 4'($urandom) | 4'h1;
		ev(3'h7, {8'h00, p, 4'hf});
		acc(1'b0, 8'h08, {6'h10, p});
		acc(1'b0, 8'h08, 10'h100);
		tsr();
		ev(3'h7, {8'h00, p, 4'h0});
		acc(1'b0, 8'h08, {6'h10, p});
		acc(1'b1, 8'h07, 10'h020);
		cs <= 1'b1;
		ev(3'h7, 16'h0000);
		acc(1'b0, 8'h08, 10'h120);
		acc(1'b0, 8'h08, 10'h120);
		xc <= 1'b1;
		ev(3'h7, 16'h0000);
		tsr();
		acc(1'b0, 8'h08, 10'h000);
		// A write while clk_en is low must leave the gates untouched
		ce <= 1'b0;
		acc(1'b1, 8'h05, 10'h03f);
		ce <= 1'b1;
		acc(1'b0, 8'h05, 10'h020);
		end_of_test();
	end
endmodule
